// >>> rtl/osdfm_pkg.sv
// constants shared by the display memory and font mapper files
// assumes one 100 MHz system clock and an 8-bit register port
package osdfm_pkg;
    // ============================================================
    // register port
    localparam int REG_AW = 4;
    localparam logic [3:0] REG_BLOCK_PTR = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_CHARSET = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [7:0] BLOCK_PTR_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CHARSET_RESET = 8'h00;
    // field positions
    localparam int PTR_PAGE_LSB = 0;
    localparam int PTR_HS_LSB = 4;
    localparam int MODE_PARALLEL = 0;
    localparam int MODE_COL80 = 1;
    localparam int MODE_LINE = 2;
    localparam int MODE_SCROLL = 3;
    localparam int CS_SUBSET_LSB = 0;
    localparam int CS_FONT_MAP_MODE = 4;
    localparam int CS_SET_UPPER = 5;
    // ============================================================
    // display storage ram layout
    localparam logic [15:0] RAM_BASE = 16'h8000;
    localparam logic [15:0] BLOCK_BYTES = 16'h0200;
    localparam logic [15:0] FULL_HALF_OFS = 16'h0400;
    localparam logic [15:0] LINE_HALF_OFS = 16'h0200;
    localparam logic [15:0] HS_ATTR_OFS = 16'h0080;
    localparam logic [15:0] ROW_ATTR_OFS = 16'h0100;
    localparam logic [4:0] ROW_ATTR_BYTES = 5'd12;
    localparam logic [4:0] LINE_ROWS = 5'd12;
    localparam logic [4:0] LINE_SCROLL_ROW = 5'd11;
    localparam logic [4:0] FULL_ROWS = 5'd24;
    localparam logic [4:0] FULL_SCROLL_ROW = 5'd23;
    localparam logic [4:0] HS_ROWS = 5'd3;
    localparam logic [6:0] HALF_COLS = 7'd40;
    localparam logic [6:0] WIDE_COLS = 7'd80;
    // ============================================================
    // font rom layout
    localparam logic [8:0] ROM_SET1_BASE = 9'h100;
    localparam logic [8:0] ROM_SET2_BASE = 9'h160;
    localparam logic [8:0] ROM_EXT_HI_BASE = 9'h1C0;
    localparam logic [8:0] ROM_SUBSET_BASE = 9'h100;
    localparam logic [8:0] SUBSET_SIZE = 9'd13;
    localparam logic [3:0] SUBSET_LAST = 4'd14;
    localparam logic [7:0] G0_FIRST = 8'h20;
    localparam logic [7:0] EXT_LO_FIRST = 8'hE0;
    localparam logic [7:0] EXT_HI_FIRST = 8'hA0;
    localparam int NAT_POSITIONS = 13;
    localparam logic [7:0] NAT_CODE [0:12] = '{8'h23, 8'h24, 8'h40, 8'h5B, 8'h5C, 8'h5D,
        8'h5E, 8'h5F, 8'h60, 8'h7B, 8'h7C, 8'h7D, 8'h7E};
    // ============================================================
    // kinds of display storage fetch
    typedef enum logic [2:0] {
        KIND_PAGE_CHAR = 3'b000,
        KIND_PAGE_ATTR = 3'b001,
        KIND_HS_CHAR = 3'b010,
        KIND_HS_ATTR = 3'b011,
        KIND_ROW_ATTR = 3'b100,
        KIND_SCROLL = 3'b101
    } osdfm_kind_t;
endpackage

// >>> rtl/osdfm_font_if.sv
// interface between the mapper top and its font address decoder
// assumes both ends sit in the clk_sys domain; the decoder is combinational
`timescale 1ns/100ps
`default_nettype none
interface osdfm_font_if;
    logic [8:0] code;
    logic css;
    logic sep;
    logic serial_mosaic;
    logic parallel_mode;
    logic triple_mode;
    logic set_upper;
    logic [3:0] subset;
    logic [8:0] rom_addr;
    logic mosaic;
    logic separated;
    logic extended;
    modport requester (output code, css, sep, serial_mosaic, parallel_mode, triple_mode,
        set_upper, subset, input rom_addr, mosaic, separated, extended);
    modport decoder (input code, css, sep, serial_mosaic, parallel_mode, triple_mode,
        set_upper, subset, output rom_addr, mosaic, separated, extended);
endinterface
`default_nettype wire

// >>> rtl/osdfm_font_map.sv
// character code to font rom address decoder, purely combinational
// assumes the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module osdfm_font_map
    import osdfm_pkg::*;
(
    // decode request and result
    osdfm_font_if.decoder f
);
    // ============================================================
    // national position match
    logic [12:0] hit;
    logic [3:0] idx;
    logic [7:0] c8;
    assign c8 = f.code[7:0];
    genvar g;
    generate
        for (g = 0; g < NAT_POSITIONS; g++) begin : g_nat
            assign hit[g] = (c8 == NAT_CODE[g]);
        end
    endgenerate
    always_comb begin
        idx = 4'd0;
        for (int i = 0; i < NAT_POSITIONS; i++) begin
            if (hit[i]) begin
                idx = 4'(i);
            end
        end
    end
    // ============================================================
    // address selection
    wire ext_sel = f.parallel_mode && f.css;
    wire low_half = ~c8[7];
    wire [1:0] set_sel = f.set_upper ? f.subset[3:2] : f.subset[1:0];
    wire [8:0] g0_rel = {1'b0, c8 - G0_FIRST};
    wire [8:0] subset_m1 = {5'd0, f.subset - 4'd1};
    wire [8:0] nat_addr = ROM_SUBSET_BASE + 9'(subset_m1 * SUBSET_SIZE) + {5'd0, idx};
    wire nat_use = (|hit) && (f.subset != 4'd0) && (f.subset <= SUBSET_LAST);
    wire [8:0] triple_addr = (set_sel == 2'd1) ? ROM_SET1_BASE + g0_rel :
        (set_sel == 2'd2) ? ROM_SET2_BASE + g0_rel : {1'b0, c8};
    wire [8:0] single_addr = nat_use ? nat_addr : {1'b0, c8};
    wire [8:0] ext_addr = (c8 >= EXT_LO_FIRST) ? {1'b0, c8 - EXT_LO_FIRST} :
        ROM_EXT_HI_BASE + {1'b0, c8 - EXT_HI_FIRST};
    wire ext_glyph = ext_sel && (c8 >= EXT_HI_FIRST);
    wire g0_code = low_half && (c8 >= G0_FIRST);
    // parallel codes with bit 8 set and charset select clear reach the rom directly (user area)
    wire upper_direct = f.parallel_mode && !f.css && f.code[8];
    assign f.mosaic = f.parallel_mode ? (f.css && low_half) : f.serial_mosaic;
    assign f.separated = f.mosaic && f.parallel_mode && f.sep;
    assign f.extended = ext_glyph;
    assign f.rom_addr = ext_glyph ? ext_addr :
        upper_direct ? f.code :
        !g0_code ? {1'b0, c8} :
        f.triple_mode ? triple_addr : single_addr;
endmodule
`default_nettype wire

// >>> rtl/osdfm_mapper.sv
// on-screen display memory and font mapper top
// assumes the renderer and register master share clk_sys; no pin inputs
`timescale 1ns/100ps
`default_nettype none
module osdfm_mapper
    import osdfm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic [osdfm_pkg::REG_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // display storage fetch request
    input wire logic ram_req,
    input wire osdfm_pkg::osdfm_kind_t ram_kind,
    input wire logic [4:0] ram_row,
    input wire logic [6:0] ram_col,
    // display storage fetch answer
    output logic [15:0] ram_addr,
    output logic ram_rd,
    output logic ram_err,
    // font fetch request
    input wire logic rom_req,
    input wire logic [8:0] char_code,
    input wire logic char_css,
    input wire logic char_sep,
    input wire logic serial_mosaic,
    // font fetch answer
    output logic [8:0] rom_addr,
    output logic rom_rd,
    output logic glyph_mosaic,
    output logic glyph_separated,
    output logic glyph_extended
);
    import osdfm_pkg::*;

    // ============================================================
    // block base decode, used for both pointers
    function automatic logic [15:0] block_base(input logic [3:0] ptr);
        block_base = RAM_BASE + 16'(ptr) * BLOCK_BYTES;
    endfunction

    // ============================================================
    // software registers
    logic [7:0] block_ptr;
    logic [7:0] mode;
    logic [7:0] charset;
    logic last_refused;

    wire wr_ptr = reg_wr && (reg_addr == REG_BLOCK_PTR);
    wire wr_mode = reg_wr && (reg_addr == REG_MODE);
    wire wr_charset = reg_wr && (reg_addr == REG_CHARSET);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            block_ptr <= BLOCK_PTR_RESET;
            mode <= MODE_RESET;
            charset <= CHARSET_RESET;
        end else begin
            if (wr_ptr) begin
                block_ptr <= reg_wdata;
            end
            if (wr_mode) begin
                mode <= reg_wdata;
            end
            if (wr_charset) begin
                charset <= reg_wdata;
            end
        end
    end

    // ============================================================
    // mode fields
    wire [3:0] page_block_pointer = block_ptr[PTR_PAGE_LSB +: 4];
    wire [3:0] header_status_block_pointer = block_ptr[PTR_HS_LSB +: 4];
    wire parallel = mode[MODE_PARALLEL];
    // 80-column layouts exist only with serial attributes
    wire col80 = mode[MODE_COL80] && !parallel;
    wire line_mode = mode[MODE_LINE];
    wire scroll_en = mode[MODE_SCROLL];
    wire font_map_mode_bit = charset[CS_FONT_MAP_MODE];
    wire set_upper = charset[CS_SET_UPPER];
    wire [3:0] national_subset_select = charset[CS_SUBSET_LSB +: 4];

    // a 1K block cannot start on an odd pointer; bit 0 is ignored there
    wire misaligned = !line_mode && page_block_pointer[0];
    wire [3:0] page_ptr_eff = line_mode ? page_block_pointer :
        {page_block_pointer[3:1], 1'b0};

    // ============================================================
    // register read, data one cycle after the strobe
    wire [7:0] status_word = {4'h0, glyph_extended, glyph_mosaic, last_refused, misaligned};
    wire [7:0] rd_mux = (reg_addr == REG_BLOCK_PTR) ? block_ptr :
        (reg_addr == REG_MODE) ? mode :
        (reg_addr == REG_CHARSET) ? charset :
        (reg_addr == REG_STATUS) ? status_word : 8'h00;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ============================================================
    // display storage address generation
    wire [15:0] page_base = block_base(page_ptr_eff);
    wire [15:0] hs_base = block_base(header_status_block_pointer);
    wire [15:0] half_ofs = line_mode ? LINE_HALF_OFS : FULL_HALF_OFS;
    wire [6:0] width = col80 ? WIDE_COLS : HALF_COLS;
    wire right_half = col80 && (ram_col >= HALF_COLS);
    wire [6:0] col_in_half = right_half ? ram_col - HALF_COLS : ram_col;
    wire [4:0] page_rows = line_mode ? LINE_ROWS : FULL_ROWS;

    // scroll fetches always land on the buffer row of the active layout
    wire [4:0] scroll_row = line_mode ? LINE_SCROLL_ROW : FULL_SCROLL_ROW;
    wire is_scroll = (ram_kind == KIND_SCROLL);
    wire [4:0] page_row = is_scroll ? scroll_row : ram_row;

    // row times 40 by shifts; the row fits in five bits
    wire [15:0] page_row16 = {11'h000, page_row};
    wire [15:0] page_row_x40 = (page_row16 << 5) + (page_row16 << 3);
    wire [15:0] hs_row16 = {11'h000, ram_row};
    wire [15:0] hs_row_x40 = (hs_row16 << 5) + (hs_row16 << 3);
    wire [15:0] hs_row_ofs = col80 ? (hs_row_x40 << 1) : hs_row_x40;

    wire [15:0] page_char_addr = page_base + (right_half ? half_ofs : 16'h0000)
        + page_row_x40 + {9'h000, col_in_half};
    wire [15:0] page_attr_addr = page_base + half_ofs + page_row_x40
        + {9'h000, ram_col};
    wire [15:0] hs_char_addr = hs_base + hs_row_ofs + {9'h000, ram_col};
    wire [15:0] hs_attr_addr = hs_base + HS_ATTR_OFS + hs_row_x40
        + {9'h000, ram_col};
    wire [15:0] row_attr_addr = hs_base + ROW_ATTR_OFS + {11'h000, ram_row};

    // ============================================================
    // legality of each fetch kind in the current mode
    wire col_ok = (ram_col < width);
    wire page_ok = col_ok && (ram_row < page_rows);
    wire hs_ok = col_ok && (ram_row < HS_ROWS);
    wire attr_ok = parallel && (ram_row < page_rows) && (ram_col < HALF_COLS);
    wire hs_attr_ok = parallel && (ram_row < HS_ROWS) && (ram_col < HALF_COLS);
    wire row_attr_ok = line_mode && (ram_row < ROW_ATTR_BYTES);
    wire scroll_ok = scroll_en && col_ok;

    logic [15:0] next_addr;
    logic next_ok;

    always_comb begin
        next_addr = 16'h0000;
        next_ok = 1'b0;
        case (ram_kind)
            KIND_PAGE_CHAR: begin
                next_addr = page_char_addr;
                next_ok = page_ok;
            end
            KIND_PAGE_ATTR: begin
                next_addr = page_attr_addr;
                next_ok = attr_ok;
            end
            KIND_HS_CHAR: begin
                next_addr = hs_char_addr;
                next_ok = hs_ok;
            end
            KIND_HS_ATTR: begin
                next_addr = hs_attr_addr;
                next_ok = hs_attr_ok;
            end
            KIND_ROW_ATTR: begin
                next_addr = row_attr_addr;
                next_ok = row_attr_ok;
            end
            KIND_SCROLL: begin
                next_addr = page_char_addr;
                next_ok = scroll_ok;
            end
            default: begin
                next_addr = 16'h0000;
                next_ok = 1'b0;
            end
        endcase
    end

    // the address holds after the strobe so the ram can sample it late
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ram_addr <= RAM_BASE;
            ram_rd <= 1'b0;
            ram_err <= 1'b0;
        end else begin
            ram_rd <= ram_req && next_ok;
            ram_err <= ram_req && !next_ok;
            if (ram_req && next_ok) begin
                ram_addr <= next_addr;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            last_refused <= 1'b0;
        end else if (ram_req) begin
            last_refused <= !next_ok;
        end
    end

    // ============================================================
    // font address decode
    osdfm_font_if font_bus ();

    // serial codes are eight bits; bit 8 and charset-select mean nothing there
    assign font_bus.code = parallel ? char_code : {1'b0, char_code[7:0]};
    assign font_bus.css = parallel && char_css;
    assign font_bus.sep = char_sep;
    assign font_bus.serial_mosaic = !parallel && serial_mosaic;
    assign font_bus.parallel_mode = parallel;
    assign font_bus.triple_mode = font_map_mode_bit;
    assign font_bus.set_upper = set_upper;
    assign font_bus.subset = national_subset_select;

    osdfm_font_map u_font_map (
        .f(font_bus.decoder)
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rom_addr <= 9'h000;
            rom_rd <= 1'b0;
            glyph_mosaic <= 1'b0;
            glyph_separated <= 1'b0;
            glyph_extended <= 1'b0;
        end else begin
            // mosaic glyphs are drawn in logic, so no rom fetch for them
            rom_rd <= rom_req && !font_bus.mosaic;
            if (rom_req) begin
                rom_addr <= font_bus.rom_addr;
                glyph_mosaic <= font_bus.mosaic;
                glyph_separated <= font_bus.separated;
                glyph_extended <= font_bus.extended;
            end
        end
    end

endmodule
`default_nettype wire

// >>> bench/osdfm_mapper_properties.sv
// concurrent checks on the mapper top ports
// assumes a bind from the bench top and one clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module osdfm_mapper_properties
    import osdfm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // display fetch
    input wire logic ram_req,
    input wire osdfm_pkg::osdfm_kind_t ram_kind,
    input wire logic [4:0] ram_row,
    input wire logic [6:0] ram_col,
    input wire logic [15:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_err,
    // font fetch
    input wire logic rom_req,
    input wire logic [8:0] char_code,
    input wire logic char_css,
    input wire logic serial_mosaic,
    input wire logic [8:0] rom_addr,
    input wire logic rom_rd,
    input wire logic glyph_mosaic,
    input wire logic glyph_extended
);
    // ============================================================
    // clocking and request shapes
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence s_row_attr_req;
        ram_req && ram_kind == KIND_ROW_ATTR;
    endsequence
    sequence s_hs_attr_req;
        ram_req && ram_kind == KIND_HS_ATTR;
    endsequence
    sequence s_plain_high;
        rom_req && !char_css && !serial_mosaic && char_code[8:7] == 2'b01;
    endsequence
    // ============================================================
    // display storage
    AST_RAM_ANSWER: assert property (ram_req |=> ram_rd != ram_err)
        else $error("fetch answer missing or doubled");
    AST_RAM_QUIET: assert property (!ram_req |=> !ram_rd && !ram_err && $stable(ram_addr))
        else $error("fetch answer without request");
    AST_RAM_BASE: assert property (ram_rd |-> ram_addr >= 16'h8000)
        else $error("fetch below storage base");
    AST_ROW_ATTR: assert property (s_row_attr_req ##1 ram_rd |->
        ram_addr[8:0] == 9'h100 + 9'($past(ram_row))) else $error("row attribute offset wrong");
    AST_ROW_LIMIT: assert property (
        ram_req && ram_kind == KIND_ROW_ATTR && ram_row >= 5'd12 |=> ram_err)
        else $error("row attribute past 12 accepted");
    AST_HS_ATTR: assert property (s_hs_attr_req ##1 ram_rd |->
        ram_addr[8:0] == 9'h080 + 9'($past(ram_row)) * 9'd40 + 9'($past(ram_col)))
        else $error("header attribute offset wrong");
    // ============================================================
    // font rom and register read
    AST_ROM_ANSWER: assert property (rom_req |=> rom_rd == !glyph_mosaic)
        else $error("font fetch answer wrong");
    AST_ROM_QUIET: assert property (!rom_req |=> !rom_rd && $stable(rom_addr))
        else $error("font answer without request");
    AST_HIGH_DIRECT: assert property (s_plain_high |=> rom_addr == {1'b0, $past(char_code[7:0])})
        else $error("high code not direct");
    AST_EXT_RANGE: assert property (glyph_extended |->
        rom_addr[8:5] == 4'h0 || rom_addr[8:6] == 3'b111) else $error("extended glyph out of range");
    AST_EXT_CSS: assert property (rom_req && !char_css |=> !glyph_extended)
        else $error("extended glyph without charset select");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

// >>> bench/osdfm_renderer_model.sv
// renderer model: issues display and font fetches at the mapper
// assumes clk_sys is shared with the mapper; one fetch at a time
`timescale 1ns/100ps
`default_nettype none
module osdfm_renderer_model
    import osdfm_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // display fetch
    output logic ram_req,
    output osdfm_pkg::osdfm_kind_t ram_kind,
    output logic [4:0] ram_row,
    output logic [6:0] ram_col,
    input wire logic [15:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_err,
    // font fetch
    output logic rom_req,
    output logic [8:0] char_code,
    output logic char_css,
    output logic char_sep,
    output logic serial_mosaic,
    input wire logic [8:0] rom_addr,
    input wire logic rom_rd,
    input wire logic glyph_mosaic,
    input wire logic glyph_separated,
    input wire logic glyph_extended
);
    initial begin
        {ram_req, ram_row, ram_col, rom_req, char_code} = '0;
        {char_css, char_sep, serial_mosaic} = '0;
        ram_kind = KIND_PAGE_CHAR;
    end
    // ============================================================
    // fetches; released row, column and code fields flip so stale values never look live
    task automatic fetch(input int k, r, c, output logic [15:0] a, output logic rd, er);
        @(posedge clk_sys);
        ram_req <= 1'b1;
        ram_kind <= osdfm_kind_t'(k[2:0]);
        ram_row <= 5'(r);
        ram_col <= 7'(c);
        @(posedge clk_sys);
        ram_req <= 1'b0;
        ram_row <= ~ram_row;
        ram_col <= ~ram_col;
        #1;
        {a, rd, er} = {ram_addr, ram_rd, ram_err};
    endtask
    task automatic font(input int code, css, sep, smos, output logic [8:0] a,
        output logic rd, m, s, x);
        @(posedge clk_sys);
        rom_req <= 1'b1;
        char_code <= 9'(code);
        {char_css, char_sep, serial_mosaic} <= {css[0], sep[0], smos[0]};
        @(posedge clk_sys);
        rom_req <= 1'b0;
        char_code <= ~char_code;
        #1;
        {a, rd, m, s, x} = {rom_addr, rom_rd, glyph_mosaic, glyph_separated, glyph_extended};
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_osdfm_mapper.sv
// self-checking bench for the display memory and font mapper
// assumes the renderer model makes every fetch request
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_osdfm_mapper;
    import osdfm_pkg::*;
    logic clk_sys, nrst, reg_wr, reg_rd, ram_req, ram_rd, ram_err, rom_req, char_css, char_sep;
    logic serial_mosaic, rom_rd, glyph_mosaic, glyph_separated, glyph_extended;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    osdfm_kind_t ram_kind;
    logic [4:0] ram_row;
    logic [6:0] ram_col;
    logic [15:0] ram_addr;
    logic [8:0] char_code, rom_addr;
    int fail_count = 0, n_compared = 0, mode, ptr, cs;
    int mode_list [12] = '{0, 4, 5, 1, 2, 6, 12, 8, 13, 10, 14, 11};
    osdfm_mapper osdfm_mapper_inst (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ram_req, .ram_kind, .ram_row, .ram_col, .ram_addr, .ram_rd, .ram_err,
        .rom_req, .char_code, .char_css, .char_sep, .serial_mosaic, .rom_addr, .rom_rd,
        .glyph_mosaic, .glyph_separated, .glyph_extended);
    osdfm_renderer_model rend (.clk_sys, .ram_req, .ram_kind, .ram_row, .ram_col, .ram_addr,
        .ram_rd, .ram_err, .rom_req, .char_code, .char_css, .char_sep, .serial_mosaic,
        .rom_addr, .rom_rd, .glyph_mosaic, .glyph_separated, .glyph_extended);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ============================================================
    // reference model
    function automatic void exp_ram(input int k, r, c, output int a, e);
        int line, wide, hb, base, lim;
        line = mode >> 2 & 1;
        wide = (mode >> 1 & 1) && !(mode & 1);
        base = 'h8000 + (line ? ptr & 15 : ptr & 14) * 'h200;
        hb = 'h8000 + (ptr >> 4 & 15) * 'h200;
        lim = wide ? 80 : 40;
        if (k == 5) r = line ? 11 : 23;
        case (k)
            0, 5: e = (k == 5) ? !(mode >> 3 & 1) || c >= lim : r >= (line ? 12 : 24) || c >= lim;
            1: e = !(mode & 1) || c >= 40 || r >= (line ? 12 : 24);
            2: e = r >= 3 || c >= lim;
            3: e = !(mode & 1) || r >= 3 || c >= 40;
            default: e = !line || r >= 12;
        endcase
        case (k)
            0, 5: a = base + r * 40 + ((c >= 40) ? (line ? 'h200 : 'h400) + c - 40 : c);
            1: a = base + (line ? 'h200 : 'h400) + r * 40 + c;
            2: a = hb + r * (wide ? 80 : 40) + c;
            3: a = hb + 'h80 + r * 40 + c;
            default: a = hb + 'h100 + r;
        endcase
    endfunction
    function automatic void exp_rom(input int code, css, smos, output int a, m, x);
        int sel;
        if (!(mode & 1)) begin
            code = code & 'hFF;
            css = 0;
        end else smos = 0;
        {a, m, x} = {code, 32'd0, 32'd0};
        sel = cs[5] ? cs >> 2 & 3 : cs & 3;
        if (smos || (css && code < 'h80)) m = 1;
        else if (css && code >= 'hA0) begin
            x = 1;
            a = (code >= 'hE0) ? code - 'hE0 : code - 'hA0 + 'h1C0;
        end else if (!css && code >= 'h20 && code < 'h80) begin
            if (cs[4]) a = (sel == 1) ? code + 'hE0 : (sel == 2) ? code + 'h140 : code;
            else for (int i = 0; i < NAT_POSITIONS; i++)
                if (code == NAT_CODE[i] && cs[3:0] inside {[1:14]}) a = 'h100 + 13 * (cs[3:0] - 1) + i;
        end
    endfunction
    // ============================================================
    // register port
    task automatic wr(input int a, d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, 4'(a), 8'(d)};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input int a, input logic [7:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, 4'(a)};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic set_regs(input int m, p, c);
        {mode, ptr, cs} = {m, p, c};
        wr(0, p);
        wr(1, m);
        wr(2, c);
        rd_chk(0, 8'(p));
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        int a, e, m, x, r, c, code, css, smos;
        logic [15:0] ga;
        logic [8:0] gr;
        logic grd, ger, gm, gs, gx;
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        void'($urandom(80));
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(i, 8'h00);
        for (int i = 4; i < 16; i++) begin
            wr(i, $urandom);
            rd_chk(i, 8'h00);
        end
        $display("test registers done");
        set_regs(0, 2, 0);
        rend.fetch(0, 1, 3, ga, grd, ger);
        `CHK(ga, 16'h842B)
        set_regs(0, 3, 0);
        rend.fetch(4, 0, 0, ga, grd, ger);
        `CHK(ger, 1'b1)
        rd_chk(3, 8'h03);
        foreach (mode_list[mi]) begin
            set_regs(mode_list[mi], $urandom_range(0, 255), 0);
            for (int k = 0; k < 6; k++) begin
                for (int j = 0; j < 16; j++) begin
                    r = $urandom_range(0, 25);
                    c = $urandom_range(0, 84);
                    rend.fetch(k, r, c, ga, grd, ger);
                    exp_ram(k, r, c, a, e);
                    `CHK(ger, e[0])
                    `CHK(grd, !e[0])
                    if (!e[0]) `CHK(ga, 16'(a))
                end
            end
        end
        $display("test display fetch done");
        for (int ci = 0; ci < 64; ci++) begin
            for (int pm = 0; pm < 2; pm++) begin
                set_regs(pm, $urandom_range(0, 255), ci);
                for (int j = 0; j < 16; j++) begin
                    code = (j < 13) ? NAT_CODE[j] : $urandom_range(0, 511);
                    css = (j < 13) ? 0 : $urandom_range(0, 1);
                    smos = (j < 13) ? 0 : $urandom_range(0, 1);
                    if (css) code = code & 'hFF;
                    rend.font(code, css, j & 1, smos, gr, grd, gm, gs, gx);
                    exp_rom(code, css, smos, a, m, x);
                    `CHK(gm, m[0])
                    `CHK(gx, x[0])
                    `CHK(grd, !m[0])
                    if (!m[0]) `CHK(gr, 9'(a))
                    `CHK(gs, 1'(m[0] && pm && (j & 1)))
                end
            end
        end
        $display("test font map done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(ram_addr, 16'h8000)
        `CHK(rom_addr, 9'h000)
        @(posedge clk_sys);
        nrst <= 1'b1;
        rd_chk(0, 8'h00);
        $display("test second reset done");
        end_of_test();
    end
    initial begin
        // over twice the cycles that the tests need
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule
bind osdfm_mapper osdfm_mapper_properties osdfm_mapper_properties_inst (.clk_sys, .nrst,
    .reg_rd, .reg_rdata, .ram_req, .ram_kind, .ram_row, .ram_col, .ram_addr, .ram_rd,
    .ram_err, .rom_req, .char_code, .char_css, .serial_mosaic, .rom_addr, .rom_rd,
    .glyph_mosaic, .glyph_extended);
`default_nettype wire
